// ==== bctr_regs.sv ====
// Timers, interrupt status, shared word and queue pointers of the terminal.
// Assumes host and engine strobes are one-cycle pulses on ref_clk_i.
// How it works
// RULE_01: time tag steps every 2,4,8,16,32 or 64 us by resolution select.
// RULE_02: tag value is stored out at message start and message end.
// RULE_03: each status bit sits at its mask bit position.
// RULE_04: status 2 holds a chain bit while status 1 has any pending event.
// RULE_05: frame countdown reads remaining frame time at 100 us per count.
// RULE_06: next-message countdown at 1 us per count; delay instruction loads it.
// RULE_07: controller mode: shared word is frame period at 100 us per count.
// RULE_08: terminal mode: shared word captures current or last command word.
// RULE_09: monitor mode: shared word is trigger; match starts, stops or flags.
// RULE_10: reset clears configuration except enhanced access enable, which sets.
// RULE_11: host may set, clear or toggle each general purpose flag.
// RULE_12: condition code read gives live engine flags.
// RULE_13: host loads queue pointer; engine advances it; readable.
// RULE_14: host loads interrupt queue pointer; processor advances; readable.
// RULE_15: data stack address tracks last word stored, host writable.
// RULE_16: no-response timeout selectable 18, 22, 50 or 130 us.
// RULE_17: legacy frame ends at 512 messages; enhanced has no limit.
// RULE_18: single frame or auto-repeat from timer or external trigger.
// RULE_19: each message's error checks are gathered into status.
// RULE_20: format and per-message options come from control word and T/R bit.
// RULE_21: engine raises four user interrupts and writes the queue.
// RULE_22: control word register shows current or last control word.
// RULE_23: time tag wraps to zero and runs continuously while enabled.
`timescale 1ns/1ps
module bctr_regs (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic [1:0] mode_i,
    input wire logic enhanced_i,
    input wire logic [2:0] tt_res_i,
    input wire logic tt_en_i,
    input wire logic message_start_sequence_i,
    input wire logic message_end_sequence_i,
    input wire logic [15:0] imask1_i,
    input wire logic [15:0] imask2_i,
    input wire logic [15:0] ievt1_i,
    input wire logic [15:0] ievt2_i,
    input wire logic [3:0] user_irq_i,
    input wire logic [9:0] msg_err_i,
    input wire logic ist1_clr_i,
    input wire logic ist2_clr_i,
    input wire logic frame_start_i,
    input wire logic auto_repeat_i,
    input wire logic ext_trig_sel_i,
    input wire logic ext_trig_i,
    input wire logic [15:0] frame_time_wr_i,
    input wire logic frame_time_we_i,
    input wire logic delay_instruction_i,
    input wire logic [15:0] delay_val_i,
    input wire logic msg_done_i,
    input wire logic [15:0] cmd_word_i,
    input wire logic cmd_valid_i,
    input wire logic [15:0] bus_word_i,
    input wire logic bus_word_valid_i,
    input wire logic [15:0] ctrl_word_i,
    input wire logic ctrl_valid_i,
    input wire logic [1:0] to_sel_i,
    input wire logic [7:0] gp_set_i,
    input wire logic [7:0] gp_clr_i,
    input wire logic [7:0] gp_tgl_i,
    input wire logic gp_we_i,
    input wire logic [7:0] eng_cc_i,
    input wire logic [15:0] ptr_wr_i,
    input wire logic gpq_we_i,
    input wire logic gpq_inc_i,
    input wire logic isq_we_i,
    input wire logic isq_inc_i,
    input wire logic dstk_we_i,
    input wire logic dstk_store_i,
    input wire logic [15:0] dstk_addr_i,
    output logic enh_access_o,
    output logic [15:0] time_tag_o,
    output logic [15:0] tag_store_o,
    output logic tag_store_we_o,
    output logic [15:0] ist1_o,
    output logic [15:0] ist2_o,
    output logic [15:0] frame_left_o,
    output logic [15:0] msg_left_o,
    output logic [15:0] shared_word_o,
    output logic trig_start_o,
    output logic trig_stop_o,
    output logic trig_irq_o,
    output logic frame_go_o,
    output logic frame_limit_o,
    output logic [7:0] response_to_us_o,
    output logic [15:0] cond_code_o,
    output logic [15:0] gpq_ptr_o,
    output logic [15:0] isq_ptr_o,
    output logic [15:0] dstk_addr_o,
    output logic [15:0] ctrl_word_o,
    output logic [1:0] ctrl_fmt_o
);
    logic ext_trig_s, ext_trig_d_r, us_tick, frame_tick, tt_tick;
    logic [5:0] tt_div_r;
    logic [5:0] tt_lim;
    logic [9:0] msg_cnt_r;
    logic [15:0] ev1;

    bctr_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .d_i(ext_trig_i),
        .q_o(ext_trig_s)
    );
    bctr_tick #(.DIV(bctr_pkg::MSG_LSB_CYC)) u_us (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clr_i(1'b0),
        .tick_o(us_tick)
    );
    bctr_tick #(.DIV(bctr_pkg::FRAME_LSB_CYC)) u_fr (
        .ref_clk_i(ref_clk_i),
        .rst_b_i(rst_b_i),
        .clr_i(frame_go_o),
        .tick_o(frame_tick)
    );

    // Enhanced access set out of reset
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            enh_access_o <= bctr_pkg::ENH_ACCESS_RST; // [RULE_10]
        else
            enh_access_o <= enh_access_o;
    end

    // Divisor of 2us ticks: 1,2,4,8,16,32
    assign tt_lim = 6'(6'h1 << tt_res_i[2:0]) - 6'h1; // [RULE_01]
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tt_div_r <= 6'h0;
            tt_tick <= 1'b0;
        end else begin
            tt_tick <= 1'b0;
            if (us_tick && tt_en_i) begin
                if (tt_div_r >= {tt_lim[4:0], 1'b1}) begin // [RULE_01]
                    tt_div_r <= 6'h0;
                    tt_tick <= 1'b1;
                end else begin
                    tt_div_r <= tt_div_r + 6'h1;
                end
            end
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            time_tag_o <= 16'h0000;
        else if (tt_tick)
            time_tag_o <= time_tag_o + 16'h1; // wraps [RULE_23]
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tag_store_o <= 16'h0000;
            tag_store_we_o <= 1'b0;
        end else begin
            tag_store_we_o <= message_start_sequence_i |
                              message_end_sequence_i; // [RULE_02]
            if (message_start_sequence_i || message_end_sequence_i)
                tag_store_o <= time_tag_o; // [RULE_02]
        end
    end

    // Sticky status; set beats clear
    assign ev1 = (ievt1_i | {msg_err_i, 2'b00, user_irq_i}) & // [RULE_19]
        imask1_i; // [RULE_03]
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ist1_o <= 16'h0000;
        end else begin
            ist1_o <= (ist1_clr_i ? 16'h0000 : ist1_o) | ev1; // [RULE_03]
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ist2_o <= 16'h0000;
        end else begin
            ist2_o <= ((ist2_clr_i ? 16'h0000 : ist2_o) |
                       (ievt2_i & imask2_i)) & 16'hFFFE; // [RULE_03]
            ist2_o[bctr_pkg::CHAIN_BIT] <=
                ((ist1_clr_i ? 16'h0000 : ist1_o) | ev1) != 16'h0; // [RULE_04]
        end
    end

    // Shared word by mode
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            shared_word_o <= 16'h0000;
        else if (frame_time_we_i && mode_i != 2'(bctr_pkg::BCTR_RT))
            shared_word_o <= frame_time_wr_i; // [RULE_07] [RULE_09]
        else if (cmd_valid_i && mode_i == 2'(bctr_pkg::BCTR_RT))
            shared_word_o <= cmd_word_i; // [RULE_08]
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trig_start_o <= 1'b0;
            trig_stop_o <= 1'b0;
            trig_irq_o <= 1'b0;
        end else begin
            trig_start_o <= 1'b0;
            trig_stop_o <= 1'b0;
            trig_irq_o <= 1'b0;
            if (bus_word_valid_i && mode_i == 2'(bctr_pkg::BCTR_MT) &&
                bus_word_i == shared_word_o) begin
                trig_start_o <= 1'b1; // [RULE_09]
                trig_stop_o <= 1'b1;
                trig_irq_o <= 1'b1;
            end
        end
    end

    // Frame start: single, timer or external edge
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ext_trig_d_r <= 1'b0;
            frame_go_o <= 1'b0;
        end else begin
            ext_trig_d_r <= ext_trig_s;
            frame_go_o <= frame_start_i ||
                (auto_repeat_i && (ext_trig_sel_i ?
                    (ext_trig_s && !ext_trig_d_r) :
                    (frame_tick && frame_left_o == 16'h1))); // [RULE_18]
        end
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            frame_left_o <= 16'h0000;
        else if (frame_go_o)
            frame_left_o <= shared_word_o; // [RULE_05] [RULE_07]
        else if (frame_tick && frame_left_o != 16'h0)
            frame_left_o <= frame_left_o - 16'h1; // [RULE_05]
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            msg_left_o <= 16'h0000;
        else if (delay_instruction_i)
            msg_left_o <= delay_val_i; // [RULE_06]
        else if (us_tick && msg_left_o != 16'h0)
            msg_left_o <= msg_left_o - 16'h1; // [RULE_06]
    end

    // Legacy message count per frame
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            msg_cnt_r <= 10'h000;
            frame_limit_o <= 1'b0;
        end else if (frame_go_o) begin
            msg_cnt_r <= 10'h000;
            frame_limit_o <= 1'b0;
        end else if (msg_done_i && !enhanced_i) begin
            msg_cnt_r <= msg_cnt_r + 10'h1;
            if (msg_cnt_r == 10'(bctr_pkg::LEGACY_MAX_MSGS - 1))
                frame_limit_o <= 1'b1; // [RULE_17]
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            response_to_us_o <= 8'(bctr_pkg::TO_18_US);
        else
            case (to_sel_i) // [RULE_16]
                2'h0: response_to_us_o <= 8'(bctr_pkg::TO_18_US);
                2'h1: response_to_us_o <= 8'(bctr_pkg::TO_22_US);
                2'h2: response_to_us_o <= 8'(bctr_pkg::TO_50_US);
                default: response_to_us_o <= 8'(bctr_pkg::TO_130_US);
            endcase
    end

    // Flags: low byte engine results, high byte general purpose
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            cond_code_o <= 16'h0000;
        else begin
            cond_code_o[7:0] <= eng_cc_i; // [RULE_12]
            if (gp_we_i)
                cond_code_o[15:8] <= ((cond_code_o[15:8] | gp_set_i) &
                    ~gp_clr_i) ^ gp_tgl_i; // [RULE_11]
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            gpq_ptr_o <= 16'h0000;
        else if (gpq_we_i)
            gpq_ptr_o <= ptr_wr_i; // [RULE_13]
        else if (gpq_inc_i)
            gpq_ptr_o <= gpq_ptr_o + 16'h1; // [RULE_13] [RULE_21]
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            isq_ptr_o <= 16'h0000;
        else if (isq_we_i)
            isq_ptr_o <= ptr_wr_i; // [RULE_14]
        else if (isq_inc_i)
            isq_ptr_o <= isq_ptr_o + 16'h1; // [RULE_14]
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i)
            dstk_addr_o <= 16'h0000;
        else if (dstk_we_i)
            dstk_addr_o <= ptr_wr_i; // [RULE_15]
        else if (dstk_store_i)
            dstk_addr_o <= dstk_addr_i; // [RULE_15]
    end
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_word_o <= 16'h0000;
            ctrl_fmt_o <= 2'h0;
        end else if (ctrl_valid_i) begin
            ctrl_word_o <= ctrl_word_i; // [RULE_22]
            ctrl_fmt_o <= {ctrl_word_i[0], cmd_word_i[10]}; // [RULE_20]
        end
    end

    tag_store_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        message_end_sequence_i |=> tag_store_we_o &&
        tag_store_o == $past(time_tag_o))
        else $error("tag not stored"); // [RULE_02]
    chain_bit_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ist2_o[0] == (ist1_o != 16'h0))
        else $error("chain bit wrong"); // [RULE_04]
    frame_count_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        frame_tick && !frame_go_o && frame_left_o != 16'h0 |=>
        frame_left_o == $past(frame_left_o) - 16'h1)
        else $error("frame count wrong"); // [RULE_05]
    delay_load_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        delay_instruction_i |=> msg_left_o == $past(delay_val_i))
        else $error("delay not loaded"); // [RULE_06]
    rt_cmd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        cmd_valid_i && mode_i == 2'h1 |=> shared_word_o == $past(cmd_word_i))
        else $error("command not held"); // [RULE_08]
    gp_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        gp_we_i && gp_set_i[0] && !gp_clr_i[0] && !gp_tgl_i[0] |=>
        cond_code_o[8])
        else $error("flag not set"); // [RULE_11]
    gpq_inc_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        gpq_inc_i && !gpq_we_i |=> gpq_ptr_o == $past(gpq_ptr_o) + 16'h1)
        else $error("queue not advanced"); // [RULE_13]
    timeout_sel_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        to_sel_i == 2'h3 |=> response_to_us_o == 8'h82)
        else $error("timeout wrong"); // [RULE_16]
    enh_reset_a: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        enh_access_o)
        else $error("enhanced access lost"); // [RULE_10]
    cv_tag: cover property (@(posedge ref_clk_i) tt_tick);
    cv_frame: cover property (@(posedge ref_clk_i) frame_go_o);
    cv_trig: cover property (@(posedge ref_clk_i) trig_irq_o);
    cv_limit: cover property (@(posedge ref_clk_i) frame_limit_o);
endmodule

// ==== bctr_pkg.sv ====
// Package for the controller timers and host register block.
// Assumes one 200 MHz clock; all users write bctr_pkg::name.
package bctr_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned US_CYC = CLK_MHZ;
    localparam int unsigned FRAME_LSB_US = 100;
    localparam int unsigned FRAME_LSB_CYC = FRAME_LSB_US * US_CYC;
    localparam int unsigned MSG_LSB_US = 1;
    localparam int unsigned MSG_LSB_CYC = MSG_LSB_US * US_CYC;
    localparam int unsigned TT_BASE_US = 2;
    localparam int unsigned TT_BASE_CYC = TT_BASE_US * US_CYC;
    localparam int unsigned LEGACY_MAX_MSGS = 512;
    localparam int unsigned TO_18_US = 18;
    localparam int unsigned TO_22_US = 22;
    localparam int unsigned TO_50_US = 50;
    localparam int unsigned TO_130_US = 130;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned CHAIN_BIT = 0;
    localparam logic [15:0] CFG_RST = 16'h0000;
    localparam logic ENH_ACCESS_RST = 1'b1;
    typedef enum logic [1:0] {
        BCTR_BC, BCTR_RT, BCTR_MT, BCTR_IDLE
    } bctr_mode_e;
    typedef enum logic [1:0] {
        BCTR_GP_HOLD, BCTR_GP_SET, BCTR_GP_CLR, BCTR_GP_TGL
    } bctr_gp_op_e;
endpackage

// ==== bctr_sync.sv ====
// Two-flop synchroniser for an outside level.
// Assumes the input is a level slow against the clock.
`timescale 1ns/1ps
module bctr_sync (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_r <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule

// ==== bctr_tick.sv ====
// Prescaler giving a one-cycle tick every DIV cycles.
// Assumes a clear input restarts the count.
`timescale 1ns/1ps
module bctr_tick #(
    parameter int unsigned DIV = 200
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic clr_i,
    output logic tick_o
);
    logic [31:0] cnt_r;
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_r <= 32'h0;
            tick_o <= 1'b0;
        end else if (clr_i) begin
            cnt_r <= 32'h0;
            tick_o <= 1'b0;
        end else if (cnt_r == 32'(DIV - 1)) begin
            cnt_r <= 32'h0;
            tick_o <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 32'h1;
            tick_o <= 1'b0;
        end
    end
endmodule

// ==== bctr_host.sv ====
// Host model: drives the flag-write and pointer-load strobes of the register block.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/1ps
module bctr_host (
    input wire logic ref_clk_i,
    output logic [7:0] gp_set_o,
    output logic [7:0] gp_clr_o,
    output logic [7:0] gp_tgl_o,
    output logic gp_we_o,
    output logic [15:0] ptr_wr_o,
    output logic gpq_we_o,
    output logic isq_we_o,
    output logic dstk_we_o
);
    initial begin
        {gp_set_o, gp_clr_o, gp_tgl_o, gp_we_o} = 25'h0000000;
        {ptr_wr_o, gpq_we_o, isq_we_o, dstk_we_o} = 19'h00000;
    end
    // One flag-register write, held for a single edge
    task automatic gp_op(input logic [7:0] s, c, t);
        gp_set_o = s;
        gp_clr_o = c;
        gp_tgl_o = t;
        gp_we_o = 1'b1;
        @(posedge ref_clk_i) #1;
        gp_we_o = 1'b0;
        // Idle edge so a following call does not re-raise the strobe at once
        @(posedge ref_clk_i) #1;
    endtask
    // Pointer load: 0 queue, 1 status queue, 2 data stack
    task automatic ptr_load(input logic [1:0] sel, input logic [15:0] v);
        ptr_wr_o = v;
        gpq_we_o = (sel == 2'h0);
        isq_we_o = (sel == 2'h1);
        dstk_we_o = (sel == 2'h2);
        @(posedge ref_clk_i) #1;
        {gpq_we_o, isq_we_o, dstk_we_o} = 3'h0;
    endtask
endmodule

// ==== bc_timers_and_host_registers_tb.sv ====
// Self-checking bench for the controller timer and register block.
// Assumes a 200 MHz clock; inputs change 1 ns after each rising edge.
`timescale 1ns/1ps
module bc_timers_and_host_registers_tb;
    logic ref_clk_i = 1'b0, rst_b_i = 1'b0;
    logic [1:0] mode_i = 2'h0, to_sel_i = 2'h0;
    logic [2:0] tt_res_i = 3'h0;
    logic enhanced_i = 1'b0, tt_en_i = 1'b0;
    logic message_start_sequence_i = 1'b0, message_end_sequence_i = 1'b0;
    logic [15:0] imask1_i = 16'hFFFF, imask2_i = 16'hFFFF;
    logic [15:0] ievt1_i = 16'h0000, ievt2_i = 16'h0000;
    logic [3:0] user_irq_i = 4'h0;
    logic [9:0] msg_err_i = 10'h000;
    logic ist1_clr_i = 1'b0, ist2_clr_i = 1'b0, frame_start_i = 1'b0;
    logic auto_repeat_i = 1'b0, ext_trig_sel_i = 1'b0, ext_trig_i = 1'b0;
    logic frame_time_we_i = 1'b0, delay_instruction_i = 1'b0;
    logic msg_done_i = 1'b0, cmd_valid_i = 1'b0, bus_word_valid_i = 1'b0;
    logic ctrl_valid_i = 1'b0, gpq_inc_i = 1'b0, isq_inc_i = 1'b0;
    logic dstk_store_i = 1'b0;
    logic [15:0] frame_time_wr_i = 16'h0000, delay_val_i = 16'h0000;
    logic [15:0] cmd_word_i = 16'h0000, bus_word_i = 16'h0000;
    logic [15:0] ctrl_word_i = 16'h0000, dstk_addr_i = 16'h0000;
    logic [7:0] eng_cc_i = 8'h00, gp_set_i, gp_clr_i, gp_tgl_i;
    logic gp_we_i, gpq_we_i, isq_we_i, dstk_we_i;
    logic [15:0] ptr_wr_i;
    logic enh_access_o, tag_store_we_o, trig_start_o, trig_stop_o;
    logic trig_irq_o, frame_go_o, frame_limit_o;
    logic [15:0] time_tag_o, tag_store_o, ist1_o, ist2_o, frame_left_o;
    logic [15:0] msg_left_o, shared_word_o, cond_code_o, gpq_ptr_o;
    logic [15:0] isq_ptr_o, dstk_addr_o, ctrl_word_o;
    logic [7:0] response_to_us_o;
    logic [1:0] ctrl_fmt_o;
    int n_fail = 0, total_checks = 0;

    bctr_host host (.ref_clk_i, .gp_set_o(gp_set_i), .gp_clr_o(gp_clr_i),
        .gp_tgl_o(gp_tgl_i), .gp_we_o(gp_we_i), .ptr_wr_o(ptr_wr_i),
        .gpq_we_o(gpq_we_i), .isq_we_o(isq_we_i), .dstk_we_o(dstk_we_i));

    bctr_regs dut (.ref_clk_i, .rst_b_i, .mode_i, .enhanced_i, .tt_res_i,
        .tt_en_i, .message_start_sequence_i, .message_end_sequence_i,
        .imask1_i, .imask2_i, .ievt1_i, .ievt2_i, .user_irq_i, .msg_err_i,
        .ist1_clr_i, .ist2_clr_i, .frame_start_i, .auto_repeat_i,
        .ext_trig_sel_i, .ext_trig_i, .frame_time_wr_i, .frame_time_we_i,
        .delay_instruction_i, .delay_val_i, .msg_done_i, .cmd_word_i,
        .cmd_valid_i, .bus_word_i, .bus_word_valid_i, .ctrl_word_i,
        .ctrl_valid_i, .to_sel_i, .gp_set_i, .gp_clr_i, .gp_tgl_i,
        .gp_we_i, .eng_cc_i, .ptr_wr_i, .gpq_we_i, .gpq_inc_i, .isq_we_i,
        .isq_inc_i, .dstk_we_i, .dstk_store_i, .dstk_addr_i, .enh_access_o,
        .time_tag_o, .tag_store_o, .tag_store_we_o, .ist1_o, .ist2_o,
        .frame_left_o, .msg_left_o, .shared_word_o, .trig_start_o,
        .trig_stop_o, .trig_irq_o, .frame_go_o, .frame_limit_o,
        .response_to_us_o, .cond_code_o, .gpq_ptr_o, .isq_ptr_o,
        .dstk_addr_o, .ctrl_word_o, .ctrl_fmt_o);

    initial begin
        forever #2.5 ref_clk_i = ~ref_clk_i;
    end

    task automatic step(input int n = 1);
        repeat (n) @(posedge ref_clk_i) #1;
    endtask
    task automatic chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d fails %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Bounded wait for a step of the time tag (sel 1) or delay count (sel 0)
    task automatic wait_chg(input bit sel, input int lim);
        logic [15:0] v;
        v = sel ? time_tag_o : msg_left_o;
        for (int k = 0; k < lim && v === (sel ? time_tag_o : msg_left_o);
             k++) step();
        if (v === (sel ? time_tag_o : msg_left_o)) begin
            $display("Error t=%0t wait ran out", $time);
            n_fail++;
            wrap_up();
        end
    endtask

    task automatic t_reset_timeout;
        logic [15:0] to_exp [4];
        to_exp = '{16'h0012, 16'h0016, 16'h0032, 16'h0082};
        chk({15'h0000, enh_access_o}, 16'h0001);
        chk({8'h00, response_to_us_o}, 16'h0012);
        chk(shared_word_o | ist1_o | gpq_ptr_o, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            to_sel_i = 2'(i);
            step(2);
            chk({8'h00, response_to_us_o}, to_exp[i]);
        end
    endtask

    task automatic t_flags_ptrs;
        host.gp_op(8'h0F, 8'h00, 8'h00);
        host.gp_op(8'h00, 8'h03, 8'h00);
        host.gp_op(8'h00, 8'h00, 8'h81);
        eng_cc_i = 8'h5A;
        step(2);
        chk(cond_code_o, 16'h8D5A);
        eng_cc_i = 8'hA5;
        step(2);
        chk(cond_code_o, 16'h8DA5);
        host.ptr_load(2'h0, 16'h0100);
        gpq_inc_i = 1'b1;
        step();
        gpq_inc_i = 1'b0;
        step();
        chk(gpq_ptr_o, 16'h0101);
        gpq_inc_i = 1'b1;
        host.ptr_load(2'h0, 16'h0200);
        gpq_inc_i = 1'b0;
        step();
        chk(gpq_ptr_o, 16'h0200);
        host.ptr_load(2'h1, 16'h0300);
        isq_inc_i = 1'b1;
        step(2);
        isq_inc_i = 1'b0;
        step();
        chk(isq_ptr_o, 16'h0302);
        host.ptr_load(2'h2, 16'h0400);
        step();
        chk(dstk_addr_o, 16'h0400);
        dstk_addr_i = 16'h0444;
        dstk_store_i = 1'b1;
        step();
        dstk_store_i = 1'b0;
        step();
        chk(dstk_addr_o, 16'h0444);
    endtask

    task automatic t_irq;
        ievt1_i = 16'h0010;
        ievt2_i = 16'h0100;
        step();
        {ievt1_i, ievt2_i} = 32'h00000000;
        step();
        chk(ist1_o & 16'h0010, 16'h0010);
        chk(ist2_o & 16'h0101, 16'h0101);
        {ist1_clr_i, ist2_clr_i} = 2'h3;
        step();
        {ist1_clr_i, ist2_clr_i} = 2'h0;
        step(2);
        chk(ist1_o | ist2_o, 16'h0000);
        user_irq_i = 4'h4;
        msg_err_i = 10'h001;
        step();
        user_irq_i = 4'h0;
        msg_err_i = 10'h000;
        step(2);
        chk(ist1_o, 16'h0044);
        chk(ist2_o & 16'h0001, 16'h0001);
        imask1_i = 16'hFFEF;
        ievt1_i = 16'h0010;
        step();
        {imask1_i, ievt1_i} = 32'hFFFF0000;
        step();
        chk(ist1_o & 16'h0010, 16'h0000);
    endtask

    task automatic t_frame;
        frame_time_wr_i = 16'h0002;
        frame_time_we_i = 1'b1;
        step();
        frame_time_we_i = 1'b0;
        step();
        chk(shared_word_o, 16'h0002);
        frame_start_i = 1'b1;
        step();
        frame_start_i = 1'b0;
        chk({15'h0000, frame_go_o}, 16'h0001);
        step();
        chk(frame_left_o, 16'h0002);
        msg_done_i = 1'b1;
        step(511);
        msg_done_i = 1'b0;
        step();
        chk({15'h0000, frame_limit_o}, 16'h0000);
        msg_done_i = 1'b1;
        step();
        msg_done_i = 1'b0;
        step();
        chk({15'h0000, frame_limit_o}, 16'h0001);
        {enhanced_i, auto_repeat_i, ext_trig_sel_i} = 3'h7;
        ext_trig_i = 1'b1;
        step();
        for (int k = 0; k < 8 && frame_go_o !== 1'b1; k++) step();
        chk({15'h0000, frame_go_o}, 16'h0001);
        ext_trig_i = 1'b0;
        auto_repeat_i = 1'b0;
        step(2);
        chk({15'h0000, frame_limit_o}, 16'h0000);
        msg_done_i = 1'b1;
        step(512);
        msg_done_i = 1'b0;
        step();
        chk({15'h0000, frame_limit_o}, 16'h0000);
        delay_val_i = 16'h0005;
        delay_instruction_i = 1'b1;
        step();
        delay_instruction_i = 1'b0;
        chk(msg_left_o, 16'h0005);
        wait_chg(1'b0, 300);
        step(200);
        chk(msg_left_o, 16'h0003);
    endtask

    task automatic t_modes;
        mode_i = 2'h1;
        frame_time_wr_i = 16'hBEEF;
        frame_time_we_i = 1'b1;
        step();
        frame_time_we_i = 1'b0;
        step();
        chk(shared_word_o, 16'h0002);
        cmd_word_i = 16'h0420;
        ctrl_word_i = 16'h0001;
        {cmd_valid_i, ctrl_valid_i} = 2'h3;
        step();
        {cmd_valid_i, ctrl_valid_i} = 2'h0;
        step();
        chk(shared_word_o, 16'h0420);
        chk(ctrl_word_o, 16'h0001);
        chk({14'h0000, ctrl_fmt_o}, 16'h0003);
        mode_i = 2'h2;
        frame_time_wr_i = 16'h1234;
        frame_time_we_i = 1'b1;
        step();
        frame_time_we_i = 1'b0;
        step();
        chk(shared_word_o, 16'h1234);
        for (int i = 0; i < 2; i++) begin
            bus_word_i = 16'h1235 - 16'(i);
            bus_word_valid_i = 1'b1;
            step();
            bus_word_valid_i = 1'b0;
            chk({trig_start_o, trig_stop_o, trig_irq_o}, 16'(i * 7));
            step();
        end
    endtask

    task automatic t_tag;
        logic [15:0] v;
        int p;
        tt_en_i = 1'b1;
        for (int r = 0; r < 6; r++) begin
            tt_res_i = 3'(r);
            p = 400 << r;
            wait_chg(1'b1, 2 * p);
            wait_chg(1'b1, p + 2);
            v = time_tag_o;
            step(p);
            chk(time_tag_o, v + 16'h0001);
        end
        tt_en_i = 1'b0;
        step(2);
        v = time_tag_o;
        for (int i = 0; i < 2; i++) begin
            message_start_sequence_i = (i == 0);
            message_end_sequence_i = (i == 1);
            step();
            {message_start_sequence_i, message_end_sequence_i} = 2'h0;
            for (int k = 0; k < 3 && tag_store_we_o !== 1'b1; k++) step();
            chk({15'h0000, tag_store_we_o}, 16'h0001);
            chk(tag_store_o, v);
            step(2);
        end
    endtask

    initial begin
        step(16);
        rst_b_i = 1'b1;
        t_reset_timeout();
        t_flags_ptrs();
        t_irq();
        t_frame();
        t_modes();
        t_tag();
        wrap_up();
    end
endmodule
